// [verilog/sram_pkg.sv]
package sram_pkg;
    localparam int          DATA_W     = 64;
    localparam int          CHK_W      = 8;
    localparam int          HAM_W      = 7;
    localparam int          WORD_AW    = 16;
    localparam int          SRAM_DEPTH = 49152;
    localparam int          BYTE_OFS   = 3;
    localparam int          LANES      = 8;
    localparam logic [2:0]  SIZE_DWORD = 3'h3;
    localparam logic        RESP_OKAY  = 1'h0;
    localparam logic        RDY_RST    = 1'h1;

    // Gray steps along idle -> read wait -> hold; the read-modify-write path enters and leaves idle with multi-bit steps.
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_RD_WAIT  = 3'h1,
        ST_RD_HOLD  = 3'h3,
        ST_WR       = 3'h2,
        ST_RMW_RD   = 3'h6,
        ST_RMW_MRG  = 3'h7,
        ST_RMW_UE   = 3'h5,
        ST_RD_ISSUE = 3'h4
    } ctrl_state_e;
endpackage : sram_pkg

// [verilog/sram_port_if.sv]
interface sram_port_if #(
    parameter int AW = 16,
    parameter int W  = 72
) ();
    logic          en;
    logic          we;
    logic [AW-1:0] addr;
    logic [W-1:0]  wdata;
    logic [W-1:0]  rdata;

    modport ctrl  (output en, output we, output addr, output wdata, input rdata);
    modport store (input en, input we, input addr, input wdata, output rdata);
endinterface : sram_port_if

// [verilog/sram_store.sv]
module sram_store #(
    parameter int AW    = 16,
    parameter int DEPTH = 49152,
    parameter int W     = 72
) (
    // Clock
    input wire logic    clk,
    // Array port
    sram_port_if.store  port
);
    logic [W-1:0] mem [DEPTH];

    if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_depth_check
        $error("sram_store: DEPTH does not fit the address width");
    end

    // Single port: a write cycle returns no read data, the output register keeps its word.
    always_ff @(posedge clk) begin
        if (port.en) begin
            if (port.we) begin
                mem[port.addr] <= port.wdata;
            end else begin
                port.rdata <= mem[port.addr];
            end
        end
    end
endmodule : sram_store

// [verilog/sram_ecc_ctrl.sv]
module sram_ecc_ctrl
    import sram_pkg::*;
#(
    parameter int AW    = sram_pkg::WORD_AW,
    parameter int DEPTH = sram_pkg::SRAM_DEPTH
) (
    // Clock, reset and enable
    input  wire logic                        MCLK,
    input  wire logic                        RESETN,
    input  wire logic                        CLKEN,
    // Bus slave
    input  wire logic                        HSEL,
    input  wire logic [31:0]                 HADDR,
    input  wire logic [1:0]                  HTRANS,
    input  wire logic                        HWRITE,
    input  wire logic [2:0]                  HSIZE,
    input  wire logic [sram_pkg::DATA_W-1:0] HWDATA,
    input  wire logic                        HREADY,
    output logic                             HREADYOUT,
    output logic                             HRESP,
    output logic [sram_pkg::DATA_W-1:0]      HRDATA,
    // Configuration
    input  wire logic                        READ_XWS,
    // Error reporting
    input  wire logic                        CE_FLAG_CLR,
    input  wire logic                        UE_FLAG_CLR,
    output logic                             CE_PULSE,
    output logic                             UE_PULSE,
    output logic [AW-1:0]                    ERR_ADDR,
    output logic                             CE_FLAG,
    output logic                             UE_FLAG,
    output logic                             FAULT_REQ
);
    import sram_pkg::*;

    localparam int NB = DATA_W + AW;
    localparam int CW = DATA_W + CHK_W;

    if (NB > (1 << HAM_W) - HAM_W - 1 || AW + BYTE_OFS > 32) begin : g_aw_check
        $error("sram_ecc_ctrl: address width too large for the check code");
    end

    typedef struct packed {
        ctrl_state_e          st;
        logic [AW-1:0]        addr;
        logic [LANES-1:0]     bmask;
        logic [AW-1:0]        maddr;
        logic                 mvld;
        logic                 rdy;
        logic                 resp;
        logic [DATA_W-1:0]    rdata;
        logic                 ce_p;
        logic                 ue_p;
        logic [AW-1:0]        eaddr;
        logic                 ce_f;
        logic                 ue_f;
        logic                 fault;
    } ctrl_s;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              ce;
        logic              ue;
    } dec_s;

    // Hamming sum over data and word address; address bits take the upper code positions.
    function automatic logic [HAM_W-1:0] ham_sum(input logic [NB-1:0] v);
        logic [HAM_W-1:0] c;
        int               k;
        c = '0;
        k = 0;
        for (int p = 1; p < (1 << HAM_W); p++) begin
            if ((p & (p - 1)) != 0) begin
                if (k < NB) begin
                    if (v[k]) begin
                        c = c ^ HAM_W'(p);
                    end
                end
                k++;
            end
        end
        return c;
    endfunction : ham_sum

    function automatic logic [CHK_W-1:0] ecc_gen(input logic [NB-1:0] v);
        logic [HAM_W-1:0] c;
        c = ham_sum(v);
        return {(^v) ^ (^c), c};
    endfunction : ecc_gen

    function automatic dec_s ecc_dec(input logic [CW-1:0] w, input logic [AW-1:0] a);
        logic [HAM_W-1:0] syn;
        logic             par;
        dec_s             d;
        int               k;
        syn    = ham_sum({a, w[DATA_W-1:0]}) ^ w[DATA_W+HAM_W-1:DATA_W];
        par    = (^w) ^ (^a);
        d.data = w[DATA_W-1:0];
        d.ce   = 1'b0;
        d.ue   = 1'b0;
        k      = 0;
        if (syn != '0 || par) begin
            if (!par) begin
                d.ue = 1'b1;
            end else if ((syn & (syn - HAM_W'(1))) == '0) begin
                d.ce = 1'b1;
            end else begin
                // Anything not landing on a data position is an address or unused-bit fault.
                d.ue = 1'b1;
                for (int p = 1; p < (1 << HAM_W); p++) begin
                    if ((p & (p - 1)) != 0) begin
                        if (HAM_W'(p) == syn && k < DATA_W) begin
                            d.data[k] = ~d.data[k];
                            d.ue      = 1'b0;
                            d.ce      = 1'b1;
                        end
                        k++;
                    end
                end
            end
        end
        return d;
    endfunction : ecc_dec

    function automatic logic [LANES-1:0] lane_mask(input logic [2:0] size, input logic [2:0] ofs);
        logic [LANES-1:0] one;
        case (size)
            3'h0:    one = 8'h01;
            3'h1:    one = 8'h03;
            3'h2:    one = 8'h0F;
            default: one = 8'hFF;
        endcase
        return LANES'(one << ofs);
    endfunction : lane_mask

    ctrl_s              s;
    ctrl_s              n;
    dec_s               cdec;
    logic [AW-1:0]      bus_w;
    logic               acc;
    logic               pf;
    logic               hit;
    logic               capt;
    logic               ev_ce;
    logic               ev_ue;
    logic               m_en;
    logic               m_we;
    logic [AW-1:0]      m_addr;
    logic [DATA_W-1:0]  wd;
    logic [DATA_W-1:0]  mask64;

    sram_port_if #(.AW(AW), .W(CW)) port ();

    sram_store #(.AW(AW), .DEPTH(DEPTH), .W(CW)) u_store (
        .clk  (MCLK),
        .port (port)
    );

    for (genvar b = 0; b < LANES; b++) begin : g_lane
        assign mask64[8*b +: 8] = {8{s.bmask[b]}};
    end

    assign bus_w = HADDR[AW+BYTE_OFS-1:BYTE_OFS];
    assign acc   = HSEL && HREADY && HTRANS[1];
    assign pf    = HSEL && HTRANS[1] && !HWRITE;
    assign hit   = s.mvld && s.maddr == bus_w;
    assign cdec  = ecc_dec(port.rdata, s.maddr);

    always_comb begin
        n      = s;
        n.ce_p = 1'b0;
        n.ue_p = 1'b0;
        // A prefetched word is trusted for one edge only, so a later unrelated read still waits.
        n.mvld = 1'b0;
        m_en   = 1'b0;
        m_we   = 1'b0;
        m_addr = bus_w;
        wd     = HWDATA;
        capt   = 1'b0;
        ev_ce  = 1'b0;
        ev_ue  = 1'b0;
        case (s.st)
            ST_IDLE, ST_WR: begin
                if (s.st == ST_WR) begin
                    m_en   = 1'b1;
                    m_we   = 1'b1;
                    m_addr = s.addr;
                    n.mvld = 1'b0;
                end
                n.st  = ST_IDLE;
                n.rdy = 1'b1;
                if (acc) begin
                    n.addr  = bus_w;
                    n.bmask = lane_mask(HSIZE, HADDR[2:0]);
                    if (!HWRITE) begin
                        if (hit && s.st == ST_IDLE) begin
                            // Fetch the next word now, since its address phase comes too late for zero waits.
                            capt    = 1'b1;
                            m_en    = 1'b1;
                            m_addr  = bus_w + AW'(1);
                            n.mvld  = 1'b1;
                            n.maddr = bus_w + AW'(1);
                        end else begin
                            // A write-back on this edge owns the port, so the read goes out late.
                            n.st  = (s.st == ST_IDLE) ? ST_RD_WAIT : ST_RD_ISSUE;
                            n.rdy = 1'b0;
                        end
                    end else if (HSIZE == SIZE_DWORD) begin
                        n.st = ST_WR;
                    end else begin
                        n.rdy = 1'b0;
                        if (s.st == ST_IDLE) begin
                            n.st    = ST_RMW_MRG;
                            m_en    = 1'b1;
                            n.mvld  = 1'b1;
                            n.maddr = bus_w;
                        end else begin
                            n.st = ST_RMW_RD;
                        end
                    end
                end
            end
            ST_RD_ISSUE, ST_RMW_RD: begin
                m_en    = 1'b1;
                m_addr  = s.addr;
                n.mvld  = 1'b1;
                n.maddr = s.addr;
                n.st    = (s.st == ST_RD_ISSUE) ? ST_RD_WAIT : ST_RMW_MRG;
            end
            ST_RD_WAIT: begin
                capt  = 1'b1;
                n.st  = READ_XWS ? ST_RD_HOLD : ST_IDLE;
                n.rdy = !READ_XWS;
            end
            ST_RD_HOLD, ST_RMW_UE: begin
                n.st  = ST_IDLE;
                n.rdy = 1'b1;
            end
            ST_RMW_MRG: begin
                if (cdec.ue) begin
                    // Regenerating the code here would turn a corrupt word into a clean one.
                    ev_ue = 1'b1;
                    n.st  = ST_RMW_UE;
                end else begin
                    ev_ce  = cdec.ce;
                    wd     = (cdec.data & ~mask64) | (HWDATA & mask64);
                    m_en   = 1'b1;
                    m_we   = 1'b1;
                    m_addr = s.addr;
                    n.mvld = 1'b0;
                    n.st   = ST_IDLE;
                    n.rdy  = 1'b1;
                end
            end
            default: begin
                n.st  = ST_IDLE;
                n.rdy = 1'b1;
            end
        endcase
        // Speculative read of the address the master is holding lets burst beats return without waits.
        if (!m_en && pf) begin
            m_en    = 1'b1;
            n.mvld  = 1'b1;
            n.maddr = bus_w;
        end
        if (capt) begin
            n.rdata = cdec.data;
            ev_ce   = cdec.ce;
            ev_ue   = cdec.ue;
        end
        n.ce_p  = ev_ce;
        n.ue_p  = ev_ue;
        if (ev_ce || ev_ue) begin
            n.eaddr = s.maddr;
        end
        n.ce_f  = (s.ce_f && !CE_FLAG_CLR) || ev_ce;
        n.ue_f  = (s.ue_f && !UE_FLAG_CLR) || ev_ue;
        n.fault = n.ce_f || n.ue_f;
        n.resp  = RESP_OKAY;
    end

    assign port.en    = m_en && CLKEN;
    assign port.we    = m_we;
    assign port.addr  = m_addr;
    assign port.wdata = {ecc_gen({s.addr, wd}), wd};

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            s <= '{st: ST_IDLE, rdy: RDY_RST, resp: RESP_OKAY, default: '0};
        end else if (CLKEN) begin
            s <= n;
        end
    end

    assign HREADYOUT = s.rdy;
    assign HRESP     = s.resp;
    assign HRDATA    = s.rdata;
    assign CE_PULSE  = s.ce_p;
    assign UE_PULSE  = s.ue_p;
    assign ERR_ADDR  = s.eaddr;
    assign CE_FLAG   = s.ce_f;
    assign UE_FLAG   = s.ue_f;
    assign FAULT_REQ = s.fault;

    a_read_one_ws: assert property (@(posedge MCLK) disable iff (!RESETN || !CLKEN)
        (s.st == ST_IDLE && acc && !HWRITE && !hit && !READ_XWS) |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read did not finish after one wait state");
    a_read_two_ws: assert property (@(posedge MCLK) disable iff (!RESETN || !CLKEN)
        (s.st == ST_IDLE && acc && !HWRITE && !hit && READ_XWS) |=> !HREADYOUT [*2] ##1 HREADYOUT)
        else $error("slow read setting did not give two wait states");
    a_burst_zero_ws: assert property (@(posedge MCLK) disable iff (!RESETN || !CLKEN)
        (s.st == ST_IDLE && acc && !HWRITE && hit) |=> HREADYOUT && HRDATA == $past(cdec.data))
        else $error("prefetched beat not returned without wait");
    a_full_write: assert property (@(posedge MCLK) disable iff (!RESETN || !CLKEN)
        (acc && HWRITE && HSIZE == SIZE_DWORD && s.rdy) |=> HREADYOUT && port.we)
        else $error("full write stalled or not stored");
    a_narrow_write: assert property (@(posedge MCLK) disable iff (!RESETN || !CLKEN)
        (acc && HWRITE && HSIZE != SIZE_DWORD && s.rdy) |=> !HREADYOUT ##[1:3] HREADYOUT)
        else $error("narrow write wait states out of range");
    a_rmw_ue_wait: assert property (@(posedge MCLK) disable iff (!RESETN || !CLKEN)
        (s.st == ST_RMW_MRG && cdec.ue) |=> !HREADYOUT ##1 HREADYOUT)
        else $error("uncorrectable read step gave no extra wait");
    a_rmw_no_wb: assert property (@(posedge MCLK) disable iff (!RESETN || !CLKEN)
        (s.st == ST_RMW_MRG && cdec.ue) |-> !port.we ##1 UE_PULSE)
        else $error("corrupt word written back or not reported");
    a_store_clean: assert property (@(posedge MCLK) disable iff (!RESETN || !CLKEN)
        port.we |-> !ecc_dec(port.wdata, s.addr).ce && !ecc_dec(port.wdata, s.addr).ue)
        else $error("stored codeword does not decode clean");
    a_pulse_cause: assert property (@(posedge MCLK) disable iff (!RESETN || !CLKEN)
        (CE_PULSE || UE_PULSE) |-> $past(ev_ce || ev_ue) && ERR_ADDR == $past(s.maddr) && !(CE_PULSE && UE_PULSE))
        else $error("error pulse without a matching decode event");
    a_flag_fault: assert property (@(posedge MCLK) disable iff (!RESETN || !CLKEN)
        (UE_PULSE || CE_PULSE) |-> FAULT_REQ && (UE_FLAG || !UE_PULSE) && (CE_FLAG || !CE_PULSE))
        else $error("error event not flagged to the fault unit");
endmodule : sram_ecc_ctrl

// [test/bus_master_model.sv]
module bus_master_model
    import sram_pkg::*;
(
    // Clock and slave answer
    input  wire logic                        mclk,
    input  wire logic                        hreadyout,
    input  wire logic [sram_pkg::DATA_W-1:0] hrdata,
    // Request lines
    output logic                             hsel,
    output logic [31:0]                      haddr,
    output logic [1:0]                       htrans,
    output logic                             hwrite,
    output logic [2:0]                       hsize,
    output logic [sram_pkg::DATA_W-1:0]      hwdata
);
    import sram_pkg::*;

    typedef struct {
        logic              wr;
        logic [2:0]        size;
        logic [31:0]       addr;
        logic [DATA_W-1:0] data;
    } op_s;

    op_s               ops[$];
    logic [DATA_W-1:0] rd_q[$];
    int                wait_q[$];
    int                seen_q[$];

    initial begin
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h0;
        hwdata = '0;
    end

    task automatic put(input logic wr, input logic [2:0] size, input logic [31:0] addr,
                       input logic [DATA_W-1:0] data);
        op_s o;
        o.wr = wr;
        o.size = size;
        o.addr = addr;
        o.data = data;
        ops.push_back(o);
    endtask : put

    task automatic drive_addr(input int i);
        if (i < ops.size()) begin
            hsel <= 1'h1;
            htrans <= 2'h2;
            haddr <= ops[i].addr;
            hwrite <= ops[i].wr;
            hsize <= ops[i].size;
        end else begin
            // Released address and write lines show the inverse so a stale value never passes for a request.
            hsel <= 1'h0;
            htrans <= 2'h0;
            haddr <= ~haddr;
            hwrite <= ~hwrite;
        end
    endtask : drive_addr

    // Queued transfers go out pipelined; each address is held until an edge samples ready high.
    task automatic run();
        int taken;
        int done;
        int w;
        int n;
        taken = 0;
        done = 0;
        w = 0;
        n = ops.size();
        rd_q.delete();
        wait_q.delete();
        seen_q.delete();
        @(posedge mclk);
        drive_addr(0);
        while (done < n) begin
            @(posedge mclk);
            if (hreadyout === 1'h1) begin
                if (done < taken) begin
                    rd_q.push_back(hrdata);
                    wait_q.push_back(w);
                    seen_q.push_back(w + 2);
                    done++;
                end
                w = 0;
                if (taken < n) begin
                    hwdata <= ops[taken].wr ? ops[taken].data : ~hwdata;
                    taken++;
                    drive_addr(taken);
                end
            end else begin
                w++;
            end
        end
        ops.delete();
    endtask : run
endmodule : bus_master_model

// [test/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sram_pkg::*;

    logic               mclk, rst_n, clken, hsel, hwrite, hready, hreadyout, hresp, read_xws;
    logic               ce_clr, ue_clr, ce_pulse, ue_pulse, ce_flag, ue_flag, fault_req;
    logic [31:0]        haddr;
    logic [1:0]         htrans;
    logic [2:0]         hsize;
    logic [DATA_W-1:0]  hwdata, hrdata;
    logic [WORD_AW-1:0] err_addr;
    int                 error_cnt = 0;
    int                 num_checks = 0;
    int                 cycle_cnt = 0;
    int                 pulse_cnt = 0;
    localparam logic [63:0] D1 = 64'h0123456789ABCDEF;

    always #25 mclk = ~mclk;
    assign hready = hreadyout;

    sram_ecc_ctrl dut_u (.MCLK(mclk), .RESETN(rst_n), .CLKEN(clken), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
        .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .READ_XWS(read_xws),
        .CE_FLAG_CLR(ce_clr), .UE_FLAG_CLR(ue_clr), .CE_PULSE(ce_pulse), .UE_PULSE(ue_pulse),
        .ERR_ADDR(err_addr), .CE_FLAG(ce_flag), .UE_FLAG(ue_flag), .FAULT_REQ(fault_req));

    bus_master_model master_u (.mclk(mclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // A hang costs one mismatch and still ends in the closing report.
    always @(posedge mclk) begin
        cycle_cnt++;
        if (ce_pulse === 1'h1 || ue_pulse === 1'h1) begin
            pulse_cnt++;
        end
        if (cycle_cnt == 3000) begin
            error_cnt++;
            $display("[FAIL] cycle limit expected below 3000 seen %0d", cycle_cnt);
            end_of_test();
        end
    end

    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    function automatic logic [63:0] merge(logic [63:0] old, logic [63:0] nw, int ofs, int sz);
        logic [63:0] r;
        r = old;
        for (int b = 0; b < 8; b++) begin
            if (b >= ofs && b < ofs + (1 << sz)) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    task automatic t_write_read();
        master_u.put(1'h1, SIZE_DWORD, 32'h200, D1);
        master_u.put(1'h0, SIZE_DWORD, 32'h200, '0);
        master_u.run();
        check("full write waits", 0, 64'(master_u.wait_q[0]));
        check("read after write waits", 2, 64'(master_u.wait_q[1]));
        check("read after write data", D1, master_u.rd_q[1]);
        check("response", {63'h0, RESP_OKAY}, {63'h0, hresp});
        master_u.put(1'h0, SIZE_DWORD, 32'h200, '0);
        master_u.run();
        check("read waits", 1, 64'(master_u.wait_q[0]));
        check("master seen cycles", 3, 64'(master_u.seen_q[0]));
        check("read data", D1, master_u.rd_q[0]);
    endtask : t_write_read

    task automatic t_slow_read();
        @(posedge mclk);
        read_xws <= 1'h1;
        ce_clr <= 1'h1;
        ue_clr <= 1'h1;
        master_u.put(1'h0, SIZE_DWORD, 32'h200, '0);
        master_u.run();
        check("slow read waits", 2, 64'(master_u.wait_q[0]));
        check("slow read data", D1, master_u.rd_q[0]);
        read_xws <= 1'h0;
        ce_clr <= 1'h0;
        ue_clr <= 1'h0;
    endtask : t_slow_read

    task automatic t_burst();
        for (int i = 0; i < 4; i++) begin
            master_u.put(1'h1, SIZE_DWORD, 32'h400 + 32'(8 * i), 64'h1111111111111111 * (i + 1));
        end
        master_u.run();
        for (int i = 0; i < 4; i++) begin
            check("burst write waits", 0, 64'(master_u.wait_q[i]));
            master_u.put(1'h0, SIZE_DWORD, 32'h400 + 32'(8 * i), '0);
        end
        master_u.run();
        for (int i = 0; i < 4; i++) begin
            check("burst read waits", (i == 0) ? 1 : 0, 64'(master_u.wait_q[i]));
            check("burst read data", 64'h1111111111111111 * (i + 1), master_u.rd_q[i]);
        end
    endtask : t_burst

    task automatic t_narrow();
        int          ofs1[3] = '{5, 6, 4};
        int          ofs2[3] = '{0, 2, 0};
        logic [63:0] nw;
        logic [63:0] exp;
        nw = 64'hFEDCBA9876543210;
        for (int sz = 0; sz < 3; sz++) begin
            master_u.put(1'h1, SIZE_DWORD, 32'h300, D1);
            master_u.put(1'h1, 3'(sz), 32'h300 + 32'(ofs1[sz]), nw);
            master_u.run();
            check("narrow after full waits", 2, 64'(master_u.wait_q[1]));
            master_u.put(1'h1, 3'(sz), 32'h300 + 32'(ofs2[sz]), ~nw);
            master_u.run();
            check("narrow alone waits", 1, 64'(master_u.wait_q[0]));
            master_u.put(1'h0, SIZE_DWORD, 32'h300, '0);
            master_u.run();
            exp = merge(merge(D1, nw, ofs1[sz], sz), ~nw, ofs2[sz], sz);
            check("merged word", exp, master_u.rd_q[0]);
        end
    endtask : t_narrow

    task automatic t_reset();
        @(posedge mclk);
        rst_n <= 1'h0;
        @(posedge mclk);
        @(negedge mclk);
        check("ready in reset", 1, {63'h0, hreadyout});
        check("read data in reset", 0, hrdata);
        check("fault in reset", 0, {61'h0, ce_pulse, ue_pulse, fault_req});
        @(posedge mclk);
        rst_n <= 1'h1;
        master_u.put(1'h0, SIZE_DWORD, 32'h200, '0);
        master_u.run();
        check("read after reset waits", 1, 64'(master_u.wait_q[0]));
        check("read after reset data", D1, master_u.rd_q[0]);
    endtask : t_reset

    // Flipped array bits stand in for a storage fault; byte address 32'h500 is word 16'hA0.
    task automatic t_ecc();
        int p0;
        p0 = pulse_cnt;
        master_u.put(1'h1, SIZE_DWORD, 32'h500, D1);
        master_u.run();
        @(negedge mclk);
        dut_u.u_store.mem[16'hA0][7] = ~dut_u.u_store.mem[16'hA0][7];
        master_u.put(1'h0, SIZE_DWORD, 32'h500, '0);
        master_u.run();
        @(posedge mclk);
        check("corrected data", D1, master_u.rd_q[0]);
        check("correctable pulses", p0 + 1, 64'(pulse_cnt));
        check("correctable flags", 64'h5, {61'h0, ce_flag, ue_flag, fault_req});
        check("error address", 64'hA0, 64'(err_addr));
        ce_clr <= 1'h1;
        @(posedge mclk);
        ce_clr <= 1'h0;
        @(negedge mclk);
        dut_u.u_store.mem[16'hA0][9] = ~dut_u.u_store.mem[16'hA0][9];
        check("cleared flag", 0, {63'h0, ce_flag});
        master_u.put(1'h0, SIZE_DWORD, 32'h500, '0);
        master_u.run();
        @(posedge mclk);
        check("uncorrected data", D1 ^ 64'h280, master_u.rd_q[0]);
        check("uncorrectable flags", 64'h3, {61'h0, ce_flag, ue_flag, fault_req});
        master_u.put(1'h1, 3'h0, 32'h500, 64'h0);
        master_u.run();
        check("uncorrectable narrow waits", 2, 64'(master_u.wait_q[0]));
        master_u.put(1'h0, SIZE_DWORD, 32'h500, '0);
        master_u.run();
        @(posedge mclk);
        check("word kept", D1 ^ 64'h280, master_u.rd_q[0]);
        check("all pulses", p0 + 4, 64'(pulse_cnt));
    endtask : t_ecc

    initial begin
        mclk = 1'h0;
        rst_n = 1'h0;
        clken = 1'h1;
        read_xws = 1'h0;
        ce_clr = 1'h0;
        ue_clr = 1'h0;
        repeat (3) @(posedge mclk);
        check("ready at reset", 1, {63'h0, hreadyout});
        rst_n <= 1'h1;
        t_write_read();
        t_slow_read();
        t_burst();
        t_narrow();
        t_reset();
        // Clean traffic must never be flagged as an error event.
        check("error pulses", 0, 64'(pulse_cnt));
        check("flags", 0, {61'h0, ce_flag, ue_flag, fault_req});
        t_ecc();
        end_of_test();
    end
endmodule : testbench
